// >>> shared/mrtp_regs.vh
// constants for the mii/rmii transmit port
`ifndef MRTP_REGS_VH
`define MRTP_REGS_VH

// data path widths
`define MRTP_NIB_W      4
`define MRTP_DIB_W      2
`define MRTP_FIFO_W     5
`define MRTP_FIFO_DEPTH 8
`define MRTP_LAST_BIT   4

// clock rates in kHz
`define MRTP_SYSCLK_KHZ 20000
`define MRTP_REFO_KHZ   10000
`define MRTP_REF_KHZ    50000
`define MRTP_FAST_KHZ   25000
`define MRTP_SLOW_KHZ   2500

// half periods and intervals, sized to the divider counter
`define MRTP_REFO_HALF  (`MRTP_SYSCLK_KHZ / (2 * `MRTP_REFO_KHZ))
`define MRTP_HALF_FAST  4'h1
`define MRTP_HALF_SLOW  4'ha
`define MRTP_RMII_SLOW  4'ha
`define MRTP_DIV_W      4

// strap settle cycles after reset release
`define MRTP_SETTLE     2'h2

// transmit states
`define MRTP_ST_IDLE    2'h0
`define MRTP_ST_SEND    2'h1
`define MRTP_ST_GAP     2'h2

`endif

// >>> src/mrtp_fifo.v
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mrtp_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // fill side
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output reg              inReady_ff,
  // drain side
  output wire             outValid,
  output wire [WIDTH-1:0] outData,
  input  wire             outReady
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr_ff;
  reg  [AW-1:0]    rdPtr_ff;
  reg  [AW:0]      count_ff;
  wire             doPush;
  wire             doPop;
  wire [AW:0]      nxt_count;

  assign outValid  = (count_ff != {(AW+1){1'b0}});
  assign outData   = mem[rdPtr_ff];
  assign doPush    = inValid & inReady_ff;
  assign doPop     = outValid & outReady;
  assign nxt_count = count_ff + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};

  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // ready is registered so the top sees a flip-flop
  always @(posedge clk) begin
    if (rst) begin
      wrPtr_ff   <= {AW{1'b0}};
      rdPtr_ff   <= {AW{1'b0}};
      count_ff   <= {(AW+1){1'b0}};
      inReady_ff <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH - 1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH - 1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      end
      count_ff   <= nxt_count;
      inReady_ff <= (nxt_count != DEPTH);
    end
  end
endmodule
`default_nettype wire

// >>> src/mrtp_ref_div.v
// divides the system clock down to the derived reference clock
`timescale 1ns/1ps
`default_nettype none
module mrtp_ref_div #(
  parameter HALF = 1,
  parameter CW   = 4
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // divided clock
  output reg  refOut_ff
);
  reg [CW-1:0] cnt_ff;

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff    <= {CW{1'b0}};
      refOut_ff <= 1'b0;
    end else if (cnt_ff == HALF - 1) begin
      cnt_ff    <= {CW{1'b0}};
      refOut_ff <= ~refOut_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> src/mrtp_transmit_port.v
// mii/rmii transmit port with strap-selected clocking
`timescale 1ns/1ps
`default_nettype none
`include "mrtp_regs.vh"

module mrtp_transmit_port #(
  parameter FIFO_W     = `MRTP_FIFO_W,
  parameter FIFO_DEPTH = `MRTP_FIFO_DEPTH,
  parameter FIFO_AW    = 3
) (
  // system clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // straps
  input  wire                    clockRoleSelect,
  input  wire                    reducedIfaceSelect,
  input  wire                    speedSlow,
  // reference clock in and derived out
  input  wire                    refClockIn,
  output wire                    derivedRefClockOut,
  // transmit clock pin
  input  wire                    txClkIn,
  output reg                     txClkOut_ff,
  output reg                     txClkOe_n_ff,
  // receive clock pin, driven only as master
  output reg                     rxClkOut_ff,
  output reg                     rxClkOe_n_ff,
  // transmit data pins
  output reg  [`MRTP_NIB_W-1:0]  txData_ff,
  output reg                     txEnable_ff,
  // user frame stream, nibble plus end-of-frame mark
  input  wire                    frameValid,
  input  wire [`MRTP_NIB_W-1:0]  frameNibble,
  input  wire                    frameLast,
  output wire                    frameReady,
  // status
  output reg                     modeRmii_ff,
  output reg                     modeMaster_ff,
  output reg                     txUnderrun_ff
);

  // ---------------------------------------------
  // derived reference output
  // ---------------------------------------------
  mrtp_ref_div #(
    .HALF (`MRTP_REFO_HALF),
    .CW   (`MRTP_DIV_W)
  ) uRefDiv (
    .clk       (clk),
    .rst       (rst),
    .refOut_ff (derivedRefClockOut)
  );

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  reg       roleSync1_ff;
  reg       roleSync2_ff;
  reg       rmiiSync1_ff;
  reg       rmiiSync2_ff;
  reg       slowSync1_ff;
  reg       slowSync2_ff;
  reg       refSync1_ff;
  reg       refSync2_ff;
  reg       refPrev_ff;
  reg       txcSync1_ff;
  reg       txcSync2_ff;
  reg       txcPrev_ff;

  always @(posedge clk) begin
    roleSync1_ff <= clockRoleSelect;
    roleSync2_ff <= roleSync1_ff;
    rmiiSync1_ff <= reducedIfaceSelect;
    rmiiSync2_ff <= rmiiSync1_ff;
    slowSync1_ff <= speedSlow;
    slowSync2_ff <= slowSync1_ff;
    refSync1_ff  <= refClockIn;
    refSync2_ff  <= refSync1_ff;
    txcSync1_ff  <= txClkIn;
    txcSync2_ff  <= txcSync1_ff;
  end

  // previous levels follow the pins through reset, so no false edge after it
  always @(posedge clk) begin
    refPrev_ff <= refSync2_ff;
    txcPrev_ff <= txcSync2_ff;
  end

  wire refRise;
  wire txcRise;
  assign refRise = refSync2_ff & ~refPrev_ff;
  assign txcRise = txcSync2_ff & ~txcPrev_ff;

  // ---------------------------------------------
  // strap capture
  // ---------------------------------------------
  // straps are pins only; no software path may change the role
  reg [1:0] settle_ff;
  reg       strapsDone_ff;
  reg       speedSlow_ff;

  always @(posedge clk) begin
    if (rst) begin
      settle_ff     <= 2'h0;
      strapsDone_ff <= 1'b0;
      modeRmii_ff   <= 1'b0;
      modeMaster_ff <= 1'b0;
      speedSlow_ff  <= 1'b0;
    end else begin
      speedSlow_ff <= slowSync2_ff;
      if (!strapsDone_ff) begin
        if (settle_ff == `MRTP_SETTLE) begin
          strapsDone_ff <= 1'b1;
          modeRmii_ff   <= rmiiSync2_ff;
          modeMaster_ff <= roleSync2_ff & ~rmiiSync2_ff;
        end else begin
          settle_ff <= settle_ff + 2'h1;
        end
      end
    end
  end

  // ---------------------------------------------
  // link timing from the reference clock
  // ---------------------------------------------
  // a 50MHz reference cannot be sampled by a 20MHz clock;
  // this port only follows references well below half clk
  reg  [`MRTP_DIV_W-1:0] refCnt_ff;
  reg                    genClk_ff;
  reg  [`MRTP_DIV_W-1:0] divLimit;
  wire                   refHit;

  always @* begin
    if (modeRmii_ff) begin
      divLimit = speedSlow_ff ? `MRTP_RMII_SLOW : 4'h1;
    end else if (speedSlow_ff) begin
      divLimit = `MRTP_HALF_SLOW;
    end else begin
      divLimit = `MRTP_HALF_FAST;
    end
  end

  assign refHit = refRise & (refCnt_ff == divLimit - 4'h1);

  always @(posedge clk) begin
    if (rst || !strapsDone_ff) begin
      refCnt_ff <= {`MRTP_DIV_W{1'b0}};
      genClk_ff <= 1'b0;
    end else if (refRise) begin
      if (refHit) begin
        refCnt_ff <= {`MRTP_DIV_W{1'b0}};
        genClk_ff <= ~genClk_ff;
      end else begin
        refCnt_ff <= refCnt_ff + 4'h1;
      end
    end
  end

  // ---------------------------------------------
  // port clock pins
  // ---------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      txClkOut_ff  <= 1'b0;
      rxClkOut_ff  <= 1'b0;
      txClkOe_n_ff <= 1'b1;
      rxClkOe_n_ff <= 1'b1;
    end else begin
      txClkOut_ff  <= modeMaster_ff & genClk_ff;
      rxClkOut_ff  <= modeMaster_ff & genClk_ff;
      txClkOe_n_ff <= ~modeMaster_ff;
      rxClkOe_n_ff <= ~modeMaster_ff;
    end
  end

  // one tick per transfer slot on the wire
  reg linkTick;
  always @* begin
    if (!strapsDone_ff) begin
      linkTick = 1'b0;
    end else if (modeRmii_ff) begin
      linkTick = refHit;
    end else if (modeMaster_ff) begin
      linkTick = refHit & ~genClk_ff;
    end else begin
      linkTick = txcRise;
    end
  end

  // ---------------------------------------------
  // frame buffer
  // ---------------------------------------------
  wire                 fifoValid;
  wire [FIFO_W-1:0]    fifoData;
  reg                  fifoPop;
  wire                 fifoInReady;

  mrtp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) uFifo (
    .clk        (clk),
    .rst        (rst),
    .inValid    (frameValid),
    .inData     ({frameLast, frameNibble}),
    .inReady_ff (fifoInReady),
    .outValid   (fifoValid),
    .outData    (fifoData),
    .outReady   (fifoPop)
  );

  assign frameReady = fifoInReady;

  // count of whole frames ends held, so a frame starts only
  // when its end is held or the fifo is full
  reg  [FIFO_AW:0] lastCnt_ff;
  wire             pushLast;
  wire             popLast;
  wire             fifoFull;

  assign pushLast = frameValid & fifoInReady & frameLast;
  assign popLast  = fifoPop & fifoData[`MRTP_LAST_BIT];
  assign fifoFull = ~fifoInReady;

  always @(posedge clk) begin
    if (rst) begin
      lastCnt_ff <= {(FIFO_AW+1){1'b0}};
    end else begin
      lastCnt_ff <= lastCnt_ff + {{FIFO_AW{1'b0}}, pushLast}
                    - {{FIFO_AW{1'b0}}, popLast};
    end
  end

  // ---------------------------------------------
  // transmit sequencer
  // ---------------------------------------------
  reg [1:0]              state_ff;
  reg [1:0]              nxt_state;
  reg [`MRTP_NIB_W-1:0]  curNib_ff;
  reg                    curLast_ff;
  reg                    highHalf_ff;
  reg [`MRTP_NIB_W-1:0]  nxt_txData;
  reg                    nxt_txEnable;
  reg [`MRTP_NIB_W-1:0]  nxt_curNib;
  reg                    nxt_curLast;
  reg                    nxt_highHalf;
  reg                    nxt_underrun;
  reg                    startOk;

  always @* begin
    startOk      = fifoValid & ((lastCnt_ff != {(FIFO_AW+1){1'b0}}) | fifoFull);
    nxt_state    = state_ff;
    nxt_txData   = txData_ff;
    nxt_txEnable = txEnable_ff;
    nxt_curNib   = curNib_ff;
    nxt_curLast  = curLast_ff;
    nxt_highHalf = highHalf_ff;
    nxt_underrun = 1'b0;
    fifoPop      = 1'b0;
    if (linkTick) begin
      case (state_ff)
        `MRTP_ST_IDLE: begin
          nxt_txEnable = 1'b0;
          if (startOk) begin
            fifoPop      = 1'b1;
            nxt_curNib   = fifoData[`MRTP_NIB_W-1:0];
            nxt_curLast  = fifoData[`MRTP_LAST_BIT];
            nxt_txEnable = 1'b1;
            nxt_state    = `MRTP_ST_SEND;
            if (modeRmii_ff) begin
              nxt_txData   = {2'h0, fifoData[`MRTP_DIB_W-1:0]};
              nxt_highHalf = 1'b1;
            end else begin
              nxt_txData = fifoData[`MRTP_NIB_W-1:0];
            end
          end
        end
        `MRTP_ST_SEND: begin
          if (modeRmii_ff && highHalf_ff) begin
            nxt_txData   = {2'h0, curNib_ff[`MRTP_NIB_W-1:`MRTP_DIB_W]};
            nxt_highHalf = 1'b0;
          end else if (curLast_ff) begin
            nxt_txEnable = 1'b0;
            nxt_txData   = 4'h0;
            nxt_state    = `MRTP_ST_GAP;
          end else if (fifoValid) begin
            fifoPop      = 1'b1;
            nxt_curNib   = fifoData[`MRTP_NIB_W-1:0];
            nxt_curLast  = fifoData[`MRTP_LAST_BIT];
            nxt_txEnable = 1'b1;
            if (modeRmii_ff) begin
              nxt_txData   = {2'h0, fifoData[`MRTP_DIB_W-1:0]};
              nxt_highHalf = 1'b1;
            end else begin
              nxt_txData = fifoData[`MRTP_NIB_W-1:0];
            end
          end else begin
            // source ran dry mid-frame: end it rather than stall
            nxt_txEnable = 1'b0;
            nxt_txData   = 4'h0;
            nxt_underrun = 1'b1;
            nxt_state    = `MRTP_ST_GAP;
          end
        end
        `MRTP_ST_GAP: begin
          nxt_txEnable = 1'b0;
          nxt_state    = `MRTP_ST_IDLE;
        end
        default: begin
          nxt_txEnable = 1'b0;
          nxt_state    = `MRTP_ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_ff      <= `MRTP_ST_IDLE;
      txData_ff     <= 4'h0;
      txEnable_ff   <= 1'b0;
      curNib_ff     <= 4'h0;
      curLast_ff    <= 1'b0;
      highHalf_ff   <= 1'b0;
      txUnderrun_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      txData_ff     <= nxt_txData;
      txEnable_ff   <= nxt_txEnable;
      curNib_ff     <= nxt_curNib;
      curLast_ff    <= nxt_curLast;
      highHalf_ff   <= nxt_highHalf;
      txUnderrun_ff <= nxt_underrun;
    end
  end

endmodule
`default_nettype wire

// >>> dv/mrtp_props.sv
// port assertions for the transmit port
`timescale 1ns/1ps
`default_nettype none
module mrtp_props (
  // clock, reset and straps
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clockRoleSelect,
  input wire logic       reducedIfaceSelect,
  // clock pins
  input wire logic       derivedRefClockOut,
  input wire logic       txClkOut_ff,
  input wire logic       txClkOe_n_ff,
  input wire logic       rxClkOut_ff,
  input wire logic       rxClkOe_n_ff,
  // link and modes
  input wire logic [3:0] txData_ff,
  input wire logic       txEnable_ff,
  input wire logic       modeRmii_ff,
  input wire logic       modeMaster_ff
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_refDiv; !$past(rst) |-> derivedRefClockOut != $past(derivedRefClockOut); endproperty
  a_refDiv: assert property (p_refDiv) else $error("ref out not clk/2");
  property p_rmii; $fell(rst) |-> ##5 modeRmii_ff == reducedIfaceSelect; endproperty
  a_rmii: assert property (p_rmii) else $error("rmii mode wrong");
  property p_master;
    $fell(rst) |-> ##5 modeMaster_ff == (clockRoleSelect && !reducedIfaceSelect);
  endproperty
  a_master: assert property (p_master) else $error("master mode wrong");
  property p_slaveOe; !modeMaster_ff |-> txClkOe_n_ff && rxClkOe_n_ff && !txClkOut_ff; endproperty
  a_slaveOe: assert property (p_slaveOe) else $error("clock pin driven as slave");
  property p_rxTx; modeMaster_ff |-> rxClkOut_ff == txClkOut_ff; endproperty
  a_rxTx: assert property (p_rxTx) else $error("rx and tx clocks differ");
  property p_dibit; modeRmii_ff |-> txData_ff[3:2] == 2'h0; endproperty
  a_dibit: assert property (p_dibit) else $error("rmii upper bits set");
  property p_gap; $fell(txEnable_ff) |-> !txEnable_ff [*3]; endproperty
  a_gap: assert property (p_gap) else $error("no gap between frames");
  property p_edge; modeMaster_ff && $changed(txData_ff) |=> $rose(txClkOut_ff); endproperty
  a_edge: assert property (p_edge) else $error("data moved off clock rise");
endmodule

bind mrtp_transmit_port mrtp_props mrtp_props_i (.clk(clk), .rst(rst),
  .clockRoleSelect(clockRoleSelect), .reducedIfaceSelect(reducedIfaceSelect),
  .derivedRefClockOut(derivedRefClockOut), .txClkOut_ff(txClkOut_ff),
  .txClkOe_n_ff(txClkOe_n_ff), .rxClkOut_ff(rxClkOut_ff), .rxClkOe_n_ff(rxClkOe_n_ff),
  .txData_ff(txData_ff), .txEnable_ff(txEnable_ff), .modeRmii_ff(modeRmii_ff),
  .modeMaster_ff(modeMaster_ff));
`default_nettype wire

// >>> dv/mrtp_phy_model.sv
// far-side phy model: link clocks and frame capture
`timescale 1ns/1ps
`default_nettype none
module mrtp_phy_model (
  // mode control
  input  wire logic       refOn,
  input  wire logic       rmii,
  input  wire logic       master,
  // device pins
  input  wire logic [3:0] txData,
  input  wire logic       txEnable,
  input  wire logic       txClkOut,
  // clocks toward the device
  output var  logic       refClk,
  output var  logic       txClk
);
  // ----
  // clocks and capture
  // ----
  logic [3:0] got[$];
  logic [1:0] low;
  int         frames = 0;
  bit         inFrame = 0;
  bit         half = 0;
  // odd start offset keeps link edges off the system clock edges
  initial begin
    refClk = 1'b0;
    txClk = 1'b0;
    #137;
    forever begin
      #200;
      refClk = refOn && !refClk;
      txClk = !rmii && !master && !txClk;
    end
  end
  task automatic take;
    if (txEnable) begin
      inFrame = 1;
      if (!rmii) got.push_back(txData);
      else if (half) got.push_back({txData[1:0], low});
      else low = txData[1:0];
      half = rmii && !half;
    end else if (inFrame) begin
      inFrame = 0;
      half = 0;
      frames++;
    end
  endtask
  always @(posedge txClk) take();
  always @(posedge refClk) if (rmii) take();
  always @(negedge txClkOut) if (master && !rmii) take();
endmodule
`default_nettype wire

// >>> dv/mii_rmii_transmit_port_tb.sv
// self-checking bench for the transmit port
`timescale 1ns/1ps
`default_nettype none
module mii_rmii_transmit_port_tb;
  // ----
  // stimulus and wiring
  // ----
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       role = 1'b0;
  logic       rmii = 1'b0;
  logic       slow = 1'b0;
  logic       refOn = 1'b0;
  logic       fValid = 1'b0;
  logic       fLast = 1'b0;
  logic [3:0] fNib = 4'h0;
  logic [3:0] exp[$];
  wire        refClk, txClk, refOut, txClkOut, txOe_n, rxClkOut, rxOe_n;
  wire        txEnable, fReady, modeRmii, modeMaster, underrun;
  wire  [3:0] txData;
  int         badCount = 0;
  int         totalChecks = 0;
  int         cycles = 0;
  int         clkRises = 0;
  int         underruns = 0;

  mrtp_transmit_port mrtp_transmit_port_i (.clk(clk), .rst(rst), .clockRoleSelect(role),
    .reducedIfaceSelect(rmii), .speedSlow(slow), .refClockIn(refClk),
    .derivedRefClockOut(refOut), .txClkIn(txClk), .txClkOut_ff(txClkOut),
    .txClkOe_n_ff(txOe_n), .rxClkOut_ff(rxClkOut), .rxClkOe_n_ff(rxOe_n),
    .txData_ff(txData), .txEnable_ff(txEnable), .frameValid(fValid), .frameNibble(fNib),
    .frameLast(fLast), .frameReady(fReady), .modeRmii_ff(modeRmii),
    .modeMaster_ff(modeMaster), .txUnderrun_ff(underrun));
  mrtp_phy_model phy_i (.refOn(refOn), .rmii(rmii), .master(role), .txData(txData),
    .txEnable(txEnable), .txClkOut(txClkOut), .refClk(refClk), .txClk(txClk));

  always #25 clk = ~clk;
  always @(posedge txClkOut) clkRises++;
  always @(posedge clk) begin
    cycles++;
    if (underrun === 1'b1) underruns++;
    if (cycles == 20000) begin
      badCount++;
      finishTest();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
    totalChecks++;
    if (seen !== want) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic doReset(input logic r, input logic m, input logic s);
    role = r;
    rmii = m;
    slow = s;
    refOn = r | m;
    rst = 1'b1;
    tick(r | m ? 20 : 2);
    exp.delete();
    phy_i.got.delete();
    phy_i.frames = 0;
    rst = 1'b0;
    tick(8);
    chk("rmii mode", modeRmii, m);
    chk("master mode", modeMaster, r & !m);
    chk("tx clock oe_n", txOe_n, !(r & !m));
    chk("rx clock oe_n", rxOe_n, !(r & !m));
  endtask
  task automatic sendFrame(input int n, input logic [3:0] base, input logic last);
    for (int i = 0; i < n; i++) begin
      fValid = 1'b1;
      fNib = base + i[3:0];
      fLast = last && i == n - 1;
      exp.push_back(fNib);
      while (fReady !== 1'b1) tick(1);
      tick(1);
    end
    fValid = 1'b0;
    fLast = 1'b0;
  endtask
  task automatic expectFrames(input int k);
    int waited;
    waited = 0;
    while (phy_i.frames < k && waited < 6000) begin
      tick(1);
      waited++;
    end
    chk("frame count", phy_i.frames, k);
    chk("nibble count", phy_i.got.size(), exp.size());
    foreach (exp[i]) chk("nibble", phy_i.got[i], exp[i]);
  endtask

  // ----
  // scenarios
  // ----
  task automatic testSlave;
    doReset(1'b0, 1'b0, 1'b0);
    sendFrame(5, 4'h5, 1'b1);
    sendFrame(3, 4'hd, 1'b1);
    expectFrames(2);
    $display("slave mii test done");
  endtask
  task automatic testMaster(input logic s);
    int c0;
    doReset(1'b1, 1'b0, s);
    @(posedge refClk);
    c0 = clkRises;
    repeat (s ? 160 : 16) @(posedge refClk);
    chk("port clock rises", clkRises - c0, 8);
    tick(1);
    sendFrame(4, 4'ha, 1'b1);
    expectFrames(1);
    $display("master mii test done");
  endtask
  task automatic testRmii;
    doReset(1'b1, 1'b1, 1'b0);
    sendFrame(4, 4'h6, 1'b1);
    expectFrames(1);
    $display("rmii test done");
  endtask
  // no frame end is pushed, so the full fifo starts the frame and then runs dry
  task automatic testUnderrun;
    int u0;
    doReset(1'b0, 1'b0, 1'b0);
    u0 = underruns;
    sendFrame(8, 4'h1, 1'b0);
    chk("ready when full", fReady, 1'b0);
    expectFrames(1);
    chk("underrun pulses", underruns - u0, 1);
    $display("fifo underrun test done");
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    testSlave();
    testMaster(1'b0);
    testMaster(1'b1);
    testRmii();
    testUnderrun();
    finishTest();
  end
endmodule
`default_nettype wire
